// ---- hdl/memmap_pkg.sv ----
// memory map constants for the address decoder
// Notes on behaviour
// - program flash dedicated-bus and system-bus windows hit one physical array
// - both small-sector windows hit one physical small-sector store
// - the three work-flash windows hit one physical work-flash array
// - dedicated-bus flash window is read-only; writes go through system-bus window
// - writes through first work-flash window carry hardware-generated ECC check bits
// - writes through third work-flash window store without ECC generation
// - fourth work-flash window serves reads of the work-flash array
// - dedicated-port ECC follows the core's own ECC setting, not a decoder setting
// - MCU config bit alias acts as single-bit read-modify-write on covered range
// - system controller bit alias acts as single-bit read-modify-write on the first 32 KB of its range
// - memory config bit alias acts as single-bit read-modify-write on the first 32 KB of its range
// - serial channel n sits in the n-th 1 KB window from the serial base
// - second converter window serves converter unit one and partial wake-up
// - CPU-internal low region outside the flash windows is accepted only from the CPU core
package memmap_pkg;

  localparam int AW = 32;

  // ---------------------------------------------------------------
  // window bases and sizes
  // ---------------------------------------------------------------
  localparam logic [31:0] CORE_LO_BASE   = 32'h0000_0000;
  localparam logic [31:0] CORE_LO_LAST   = 32'h01FF_FFFF;
  localparam logic [31:0] DBF_BASE       = 32'h00A0_0000;
  localparam logic [31:0] SBF_BASE       = 32'h01A0_0000;
  localparam logic [31:0] DBF_SS_BASE    = 32'h009F_0000;
  localparam logic [31:0] SBF_SS_BASE    = 32'h019F_0000;
  localparam logic [31:0] PF_SIZE        = 32'h0010_0000;
  localparam logic [31:0] SS_SIZE        = 32'h0001_0000;
  localparam logic [31:0] WF1_BASE       = 32'h0E00_0000;
  localparam logic [31:0] WF3_BASE       = 32'h0E20_0000;
  localparam logic [31:0] WF4_BASE       = 32'h0E30_0000;
  localparam logic [31:0] WF_SIZE        = 32'h0001_0000;
  localparam logic [31:0] SEC_BASE       = 32'hB200_0000;
  localparam logic [31:0] SEC_LAST       = 32'hB20F_FFFF;
  localparam logic [31:0] MCU_ALIAS_BASE = 32'hB080_0000;
  localparam logic [31:0] MCU_ALIAS_LAST = 32'hB0FF_FFFF;
  localparam logic [31:0] MCU_BASE       = 32'hB060_0000;
  localparam logic [31:0] SYS_ALIAS_BASE = 32'hB100_0000;
  localparam logic [31:0] SYS_ALIAS_LAST = 32'hB10F_FFFF;
  localparam logic [31:0] SYS_BASE       = 32'hB030_0000;
  localparam logic [31:0] SYS_LAST       = 32'hB031_FFFF;
  localparam logic [31:0] MEM_ALIAS_BASE = 32'hB110_0000;
  localparam logic [31:0] MEM_ALIAS_LAST = 32'hB11F_FFFF;
  localparam logic [31:0] MEM_BASE       = 32'hB040_0000;
  localparam logic [31:0] MEM_LAST       = 32'hB041_FFFF;
  localparam logic [31:0] SER_BASE       = 32'hB480_0000;
  localparam logic [31:0] SER_WIN        = 32'h0000_0400;
  localparam int          SER_CH         = 4;
  localparam logic [31:0] CNV0_BASE      = 32'hB484_8000;
  localparam logic [31:0] CNV1_BASE      = 32'hB484_8400;
  localparam logic [31:0] CNV_WIN        = 32'h0000_0400;

  // ---------------------------------------------------------------
  // bit alias geometry: alias word -> target byte and bit
  // ---------------------------------------------------------------
  localparam int          BIT_SEL_LSB    = 2;
  localparam int          BIT_SEL_W      = 3;
  localparam int          BYTE_LSB       = 5;
  localparam int          MCU_SPAN_W     = 18;
  localparam int          SYS_SPAN_W     = 17;
  localparam int          MEM_SPAN_W     = 17;

  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;
  localparam logic [1:0]  RESP_DECERR    = 2'h3;

  typedef enum logic [3:0] {
    TGT_NONE    = 4'h0,
    TGT_PFLASH  = 4'h1,
    TGT_SSFLASH = 4'h2,
    TGT_WFLASH  = 4'h3,
    TGT_CORE    = 4'h4,
    TGT_SERIAL  = 4'h5,
    TGT_CNV0    = 4'h6,
    TGT_CNV1    = 4'h7,
    TGT_BITRMW  = 4'h8,
    TGT_PERI    = 4'h9
  } target_e;

  typedef enum logic [1:0] {
    ECC_CORE = 2'h0,
    ECC_GEN  = 2'h1,
    ECC_RAW  = 2'h2,
    ECC_CHK  = 2'h3
  } ecc_mode_e;

endpackage

// ---- hdl/addr_window_match.sv ----
// range compare of one address against a window
`timescale 1ns/1ns
module addr_window_match
#(
  parameter logic [31:0] BASE = 32'h0000_0000,
  parameter logic [31:0] LAST = 32'h0000_0000
)
(
  input  wire logic [31:0] addr,
  output wire logic        hit,
  output wire logic [31:0] offset
);
  assign hit    = (addr >= BASE) && (addr <= LAST);
  assign offset = addr - BASE;
endmodule // addr_window_match

// ---- hdl/bit_rmw_unit.sv ----
// single-bit read-modify-write on a target word
`timescale 1ns/1ns
module bit_rmw_unit
(
  input  wire logic [31:0] old_word,
  input  wire logic [4:0]  bit_pos,
  input  wire logic        bit_val,
  output wire logic [31:0] new_word,
  output wire logic        bit_out
);
  wire logic [31:0] sel_mask;

  assign sel_mask = 32'h0000_0001 << bit_pos;
  assign new_word = bit_val ? (old_word | sel_mask) : (old_word & ~sel_mask);
  assign bit_out  = old_word[bit_pos];
endmodule // bit_rmw_unit

// ---- hdl/memory_map_decoder.sv ----
// address decoder with flash, work-flash and bit alias steering
`timescale 1ns/1ns
module memory_map_decoder
  import memmap_pkg::*;
(
  input  wire logic                 CLK,
  input  wire logic                 RST_B,
  input  wire logic                 CE,
  input  wire logic                 REQ_VALID,
  input  wire logic [31:0]          REQ_ADDR,
  input  wire logic                 REQ_WRITE,
  input  wire logic [31:0]          REQ_WDATA,
  input  wire logic                 REQ_FROM_CORE,
  input  wire logic                 REQ_DEDICATED,
  input  wire logic                 SEC_PRESENT,
  input  wire logic [31:0]          TGT_RDATA,
  output logic                      OUT_VALID,
  output memmap_pkg::target_e       OUT_TARGET,
  output logic [31:0]               OUT_ADDR,
  output logic                      OUT_WRITE,
  output logic [31:0]               OUT_WDATA,
  output memmap_pkg::ecc_mode_e     OUT_ECC,
  output logic [1:0]                OUT_CHANNEL,
  output logic                      OUT_WAKE_SEL,
  output logic                      OUT_RMW,
  output logic                      RESP_VALID,
  output logic [1:0]                RESP_CODE,
  output logic [31:0]               RESP_RDATA
);
  import memmap_pkg::*;

  // ---------------------------------------------------------------
  // window hits
  // ---------------------------------------------------------------
  wire logic        hit_core_lo;
  wire logic        hit_dbf;
  wire logic        hit_sbf;
  wire logic        hit_dbf_ss;
  wire logic        hit_sbf_ss;
  wire logic        hit_wf1;
  wire logic        hit_wf3;
  wire logic        hit_wf4;
  wire logic        hit_sec;
  wire logic        hit_mcu_a;
  wire logic        hit_sys_a;
  wire logic        hit_mem_a;
  wire logic        hit_cnv0;
  wire logic        hit_cnv1;
  wire logic [31:0] off_dbf;
  wire logic [31:0] off_sbf;
  wire logic [31:0] off_dbf_ss;
  wire logic [31:0] off_sbf_ss;
  wire logic [31:0] off_wf1;
  wire logic [31:0] off_wf3;
  wire logic [31:0] off_wf4;
  wire logic [31:0] off_mcu_a;
  wire logic [31:0] off_sys_a;
  wire logic [31:0] off_mem_a;
  wire logic [31:0] off_cnv0;
  wire logic [31:0] off_cnv1;

  addr_window_match #(.BASE(CORE_LO_BASE), .LAST(CORE_LO_LAST)) u_core
    (.addr(REQ_ADDR), .hit(hit_core_lo), .offset());
  addr_window_match #(.BASE(DBF_BASE), .LAST(DBF_BASE + PF_SIZE - 32'h1)) u_dbf
    (.addr(REQ_ADDR), .hit(hit_dbf), .offset(off_dbf));
  addr_window_match #(.BASE(SBF_BASE), .LAST(SBF_BASE + PF_SIZE - 32'h1)) u_sbf
    (.addr(REQ_ADDR), .hit(hit_sbf), .offset(off_sbf));
  addr_window_match #(.BASE(DBF_SS_BASE), .LAST(DBF_SS_BASE + SS_SIZE - 32'h1)) u_dss
    (.addr(REQ_ADDR), .hit(hit_dbf_ss), .offset(off_dbf_ss));
  addr_window_match #(.BASE(SBF_SS_BASE), .LAST(SBF_SS_BASE + SS_SIZE - 32'h1)) u_sss
    (.addr(REQ_ADDR), .hit(hit_sbf_ss), .offset(off_sbf_ss));
  addr_window_match #(.BASE(WF1_BASE), .LAST(WF1_BASE + WF_SIZE - 32'h1)) u_wf1
    (.addr(REQ_ADDR), .hit(hit_wf1), .offset(off_wf1));
  addr_window_match #(.BASE(WF3_BASE), .LAST(WF3_BASE + WF_SIZE - 32'h1)) u_wf3
    (.addr(REQ_ADDR), .hit(hit_wf3), .offset(off_wf3));
  addr_window_match #(.BASE(WF4_BASE), .LAST(WF4_BASE + WF_SIZE - 32'h1)) u_wf4
    (.addr(REQ_ADDR), .hit(hit_wf4), .offset(off_wf4));
  addr_window_match #(.BASE(SEC_BASE), .LAST(SEC_LAST)) u_sec
    (.addr(REQ_ADDR), .hit(hit_sec), .offset());
  addr_window_match #(.BASE(MCU_ALIAS_BASE), .LAST(MCU_ALIAS_LAST)) u_mcua
    (.addr(REQ_ADDR), .hit(hit_mcu_a), .offset(off_mcu_a));
  addr_window_match #(.BASE(SYS_ALIAS_BASE), .LAST(SYS_ALIAS_LAST)) u_sysa
    (.addr(REQ_ADDR), .hit(hit_sys_a), .offset(off_sys_a));
  addr_window_match #(.BASE(MEM_ALIAS_BASE), .LAST(MEM_ALIAS_LAST)) u_mema
    (.addr(REQ_ADDR), .hit(hit_mem_a), .offset(off_mem_a));
  addr_window_match #(.BASE(CNV0_BASE), .LAST(CNV0_BASE + CNV_WIN - 32'h1)) u_cnv0
    (.addr(REQ_ADDR), .hit(hit_cnv0), .offset(off_cnv0));
  addr_window_match #(.BASE(CNV1_BASE), .LAST(CNV1_BASE + CNV_WIN - 32'h1)) u_cnv1
    (.addr(REQ_ADDR), .hit(hit_cnv1), .offset(off_cnv1));

  // ---------------------------------------------------------------
  // serial channels, one 1 KB window each
  // ---------------------------------------------------------------
  wire logic [SER_CH-1:0] ser_hit;
  wire logic [1:0]        ser_idx;
  wire logic [31:0]       ser_off;

  genvar gi;
  generate
    for (gi = 0; gi < SER_CH; gi++)
    begin : g_ser
      assign ser_hit[gi] = (REQ_ADDR >= SER_BASE + SER_WIN * gi) &&
                           (REQ_ADDR <  SER_BASE + SER_WIN * (gi + 1));
    end
  endgenerate

  assign ser_idx = ser_hit[3] ? 2'h3 : ser_hit[2] ? 2'h2 : ser_hit[1] ? 2'h1 : 2'h0;
  assign ser_off = REQ_ADDR - SER_BASE;

  // ---------------------------------------------------------------
  // bit alias address translation
  // ---------------------------------------------------------------
  // each alias word stands for one bit: word index selects byte and bit
  wire logic        hit_alias;
  wire logic [31:0] alias_off;
  wire logic [31:0] alias_tgt;
  wire logic [4:0]  alias_bit;
  wire logic [31:0] alias_byte;

  assign hit_alias = hit_mcu_a | hit_sys_a | hit_mem_a;
  assign alias_off = hit_mcu_a ? off_mcu_a : hit_sys_a ? off_sys_a : off_mem_a;
  assign alias_byte = alias_off >> BYTE_LSB;
  assign alias_bit = {alias_byte[1:0],
                      alias_off[BIT_SEL_LSB +: BIT_SEL_W]};
  assign alias_tgt =
    hit_mcu_a ? (MCU_BASE + {14'h0, alias_byte[MCU_SPAN_W-1:2], 2'h0}) :
    hit_sys_a ? (SYS_BASE + {15'h0, alias_byte[SYS_SPAN_W-1:2], 2'h0}) :
                (MEM_BASE + {15'h0, alias_byte[MEM_SPAN_W-1:2], 2'h0});

  // ---------------------------------------------------------------
  // target and error selection
  // ---------------------------------------------------------------
  wire logic      core_only_blk;
  wire logic      sec_blk;
  wire logic      ro_blk;
  wire logic      wf_dir_blk;
  wire logic      any_flash;
  wire logic      hit_wf;
  wire target_e   sel_tgt;
  wire logic [31:0] sel_addr;
  wire ecc_mode_e sel_ecc;
  wire logic      sel_err;

  assign hit_wf    = hit_wf1 | hit_wf3 | hit_wf4;
  assign any_flash = hit_dbf | hit_sbf | hit_dbf_ss | hit_sbf_ss;
  // other masters reach the low region only through its flash windows
  assign core_only_blk = hit_core_lo && !REQ_FROM_CORE && !any_flash;
  assign sec_blk   = hit_sec && !SEC_PRESENT;
  assign ro_blk    = (hit_dbf | hit_dbf_ss) && REQ_WRITE;
  // window 1 and 3 are write paths, window 4 the read path
  assign wf_dir_blk = ((hit_wf1 | hit_wf3) && !REQ_WRITE) ||
                      (hit_wf4 && REQ_WRITE);

  assign sel_tgt =
    (hit_dbf | hit_sbf)       ? TGT_PFLASH  :
    (hit_dbf_ss | hit_sbf_ss) ? TGT_SSFLASH :
    hit_wf                    ? TGT_WFLASH  :
    hit_core_lo               ? TGT_CORE    :
    (|ser_hit)                ? TGT_SERIAL  :
    hit_cnv0                  ? TGT_CNV0    :
    hit_cnv1                  ? TGT_CNV1    :
    hit_alias                 ? TGT_BITRMW  :
    hit_sec                   ? TGT_PERI    :
                                TGT_NONE;

  assign sel_addr =
    hit_dbf    ? off_dbf    : hit_sbf    ? off_sbf    :
    hit_dbf_ss ? off_dbf_ss : hit_sbf_ss ? off_sbf_ss :
    hit_wf1    ? off_wf1    : hit_wf3    ? off_wf3    :
    hit_wf4    ? off_wf4    :
    (|ser_hit) ? {22'h0, ser_off[9:0]} :
    hit_cnv0   ? off_cnv0   : hit_cnv1   ? off_cnv1   :
    hit_alias  ? alias_tgt  : REQ_ADDR;

  assign sel_ecc = hit_wf1 ? ECC_GEN :
                   hit_wf3 ? ECC_RAW :
                   hit_wf4 ? ECC_CHK :
                   ECC_CORE;

  assign sel_err = (sel_tgt == TGT_NONE) || core_only_blk || sec_blk ||
                   ro_blk || wf_dir_blk;

  // ---------------------------------------------------------------
  // bit read-modify-write sequencing
  // ---------------------------------------------------------------
  // alias writes read the target, patch one bit, write it back
  typedef enum logic [1:0] {
    ST_IDLE  = 2'h0,
    ST_READ  = 2'h1,
    ST_WRITE = 2'h2
  } rmw_state_e;

  rmw_state_e  state_ff;
  rmw_state_e  nxt_state;
  logic [4:0]  bit_ff;
  logic        bval_ff;
  logic        wr_ff;
  logic [31:0] tgt_ff;
  wire logic [31:0] patched;
  wire logic        bit_rd;
  wire logic        start_rmw;
  wire logic        take;

  assign take      = CE && REQ_VALID && state_ff == ST_IDLE;
  assign start_rmw = take && hit_alias && !sel_err;

  bit_rmw_unit u_rmw
  (
    .old_word (TGT_RDATA),
    .bit_pos  (bit_ff),
    .bit_val  (bval_ff),
    .new_word (patched),
    .bit_out  (bit_rd)
  );

  always_comb
  begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_IDLE:  nxt_state = start_rmw ? ST_READ : ST_IDLE;
      ST_READ:  nxt_state = wr_ff ? ST_WRITE : ST_IDLE;
      ST_WRITE: nxt_state = ST_IDLE;
      default:  nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge CLK)
  begin
    if (!RST_B)
    begin
      state_ff <= ST_IDLE;
      bit_ff   <= 5'h0;
      bval_ff  <= 1'b0;
      wr_ff    <= 1'b0;
      tgt_ff   <= 32'h0;
    end
    else if (CE)
    begin
      state_ff <= nxt_state;
      if (start_rmw)
      begin
        bit_ff  <= alias_bit;
        bval_ff <= REQ_WDATA[0];
        wr_ff   <= REQ_WRITE;
        tgt_ff  <= alias_tgt;
      end
    end
  end

  // ---------------------------------------------------------------
  // registered outputs
  // ---------------------------------------------------------------
  always_ff @(posedge CLK)
  begin
    if (!RST_B)
    begin
      OUT_VALID    <= 1'b0;
      OUT_TARGET   <= TGT_NONE;
      OUT_ADDR     <= 32'h0;
      OUT_WRITE    <= 1'b0;
      OUT_WDATA    <= 32'h0;
      OUT_ECC      <= ECC_CORE;
      OUT_CHANNEL  <= 2'h0;
      OUT_WAKE_SEL <= 1'b0;
      OUT_RMW      <= 1'b0;
      RESP_VALID   <= 1'b0;
      RESP_CODE    <= RESP_OKAY;
      RESP_RDATA   <= 32'h0;
    end
    else if (CE)
    begin
      OUT_VALID  <= 1'b0;
      RESP_VALID <= 1'b0;
      OUT_RMW    <= 1'b0;
      if (take && sel_err)
      begin
        RESP_VALID <= 1'b1;
        RESP_CODE  <= (sel_tgt == TGT_NONE) ? RESP_DECERR : RESP_SLVERR;
        RESP_RDATA <= 32'h0;
      end
      else if (start_rmw)
      begin
        OUT_VALID  <= 1'b1;
        OUT_TARGET <= TGT_BITRMW;
        OUT_ADDR   <= alias_tgt;
        OUT_WRITE  <= 1'b0;
        OUT_RMW    <= 1'b1;
        OUT_ECC    <= ECC_CORE;
      end
      else if (take)
      begin
        OUT_VALID    <= 1'b1;
        OUT_TARGET   <= sel_tgt;
        OUT_ADDR     <= sel_addr;
        OUT_WRITE    <= REQ_WRITE;
        OUT_WDATA    <= REQ_WDATA;
        OUT_ECC      <= sel_ecc;
        OUT_CHANNEL  <= ser_idx;
        OUT_WAKE_SEL <= hit_cnv1;
        RESP_VALID   <= 1'b1;
        RESP_CODE    <= RESP_OKAY;
        RESP_RDATA   <= 32'h0;
      end
      else if (state_ff == ST_READ && wr_ff)
      begin
        OUT_VALID <= 1'b1;
        OUT_ADDR  <= tgt_ff;
        OUT_WRITE <= 1'b1;
        OUT_WDATA <= patched;
        OUT_RMW   <= 1'b1;
      end
      else if (state_ff == ST_READ)
      begin
        RESP_VALID <= 1'b1;
        RESP_CODE  <= RESP_OKAY;
        RESP_RDATA <= {31'h0, bit_rd};
      end
      else if (state_ff == ST_WRITE)
      begin
        RESP_VALID <= 1'b1;
        RESP_CODE  <= RESP_OKAY;
      end
    end
  end
endmodule // memory_map_decoder

// ---- tb/mmd_props.sv ----
// assertion checker for the memory map decoder ports
`timescale 1ns/1ns
module mmd_props
(
  input wire logic                 CLK,
  input wire logic                 RST_B,
  input wire logic                 CE,
  input wire logic                 REQ_VALID,
  input wire logic [31:0]          REQ_ADDR,
  input wire logic                 REQ_WRITE,
  input wire logic                 REQ_FROM_CORE,
  input wire logic                 OUT_VALID,
  input wire memmap_pkg::target_e  OUT_TARGET,
  input wire logic [31:0]          OUT_ADDR,
  input wire logic                 OUT_WRITE,
  input wire memmap_pkg::ecc_mode_e OUT_ECC,
  input wire logic [1:0]           OUT_CHANNEL,
  input wire logic                 OUT_WAKE_SEL,
  input wire logic                 OUT_RMW,
  input wire logic                 RESP_VALID,
  input wire logic [1:0]           RESP_CODE
);
  import memmap_pkg::*;
  logic [1:0] busy_ff;
  // alias sequences swallow requests, so only idle cycles count as takes
  wire logic alias_hit = REQ_ADDR[31:23] == 9'h161 || REQ_ADDR[31:21] == 11'h588;
  wire logic take = CE && REQ_VALID && busy_ff == 2'h0;
  wire logic [1:0] nxt_busy = !CE ? busy_ff : busy_ff != 2'h0 ? busy_ff - 2'h1 :
                              (take && alias_hit) ? (REQ_WRITE ? 2'h2 : 2'h1) : 2'h0;
  wire logic pf = REQ_ADDR[31:20] == 12'h00A || REQ_ADDR[31:20] == 12'h01A;
  wire logic ss = REQ_ADDR[31:16] == 16'h009F || REQ_ADDR[31:16] == 16'h019F;
  wire logic wf1 = REQ_ADDR[31:16] == 16'h0E00;
  wire logic wf3 = REQ_ADDR[31:16] == 16'h0E20;
  wire logic wf4 = REQ_ADDR[31:16] == 16'h0E30;
  always_ff @(posedge CLK)
    busy_ff <= RST_B ? nxt_busy : 2'h0;
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_B);
  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  pflash_map_a: assert property (take && !REQ_WRITE && pf |=> OUT_VALID
    && OUT_TARGET == TGT_PFLASH && OUT_ADDR == ($past(REQ_ADDR) & 32'h000F_FFFF))
    else $error("flash window steering wrong");
  sector_map_a: assert property (take && !REQ_WRITE && ss |=> OUT_VALID
    && OUT_TARGET == TGT_SSFLASH && OUT_ADDR == ($past(REQ_ADDR) & 32'h0000_FFFF))
    else $error("small sector steering wrong");
  ded_readonly_a: assert property (take && REQ_WRITE && REQ_ADDR[31:16] inside
    {[16'h009F:16'h00AF]} |=> RESP_VALID && RESP_CODE == RESP_SLVERR && !OUT_VALID)
    else $error("dedicated flash write not refused");
  wf_ecc_a: assert property (take && REQ_WRITE && (wf1 || wf3) |=> OUT_VALID
    && OUT_TARGET == TGT_WFLASH && OUT_ECC == ($past(wf3) ? ECC_RAW : ECC_GEN))
    else $error("work flash ecc mode wrong");
  wf_read_a: assert property (take && !REQ_WRITE && wf4 |=> OUT_VALID && !OUT_WRITE
    && OUT_TARGET == TGT_WFLASH && OUT_ADDR == ($past(REQ_ADDR) & 32'h0000_FFFF))
    else $error("work flash read window wrong");
  core_ecc_a: assert property (take && !REQ_WRITE && REQ_ADDR[31:20] == 12'h00A
    |=> OUT_ECC == ECC_CORE) else $error("dedicated read ecc not core");
  serial_sel_a: assert property (take && REQ_ADDR[31:12] == 20'hB4800 |=>
    OUT_TARGET == TGT_SERIAL && {30'h0, OUT_CHANNEL} == (($past(REQ_ADDR) >> 10) & 32'h3))
    else $error("serial channel select wrong");
  conv_sel_a: assert property (take && REQ_ADDR[31:10] == CNV1_BASE[31:10]
    |=> OUT_TARGET == TGT_CNV1 && OUT_WAKE_SEL) else $error("converter one select wrong");
  low_region_a: assert property (take && REQ_ADDR[31:25] == 7'h0 && !pf && !ss
    && !REQ_FROM_CORE |=> RESP_VALID && RESP_CODE == RESP_SLVERR && !OUT_VALID)
    else $error("low region open to non-core");
  reserved_err_a: assert property (take && REQ_ADDR[31:28] == 4'hC |=> RESP_VALID
    && RESP_CODE == RESP_DECERR && !OUT_VALID) else $error("reserved access not refused");
  alias_seq_a: assert property (take && alias_hit && REQ_WRITE |=> OUT_RMW
    && !OUT_WRITE ##1 OUT_RMW && OUT_WRITE ##1 RESP_VALID && RESP_CODE == RESP_OKAY)
    else $error("bit alias write sequence wrong");
endmodule // mmd_props

// ---- tb/tgt_model.sv ----
// target-side word store answering the decoder's alias beats
`timescale 1ns/1ns
module tgt_model
(
  input  wire logic        CLK,
  input  wire logic        OUT_VALID,
  input  wire logic        OUT_RMW,
  input  wire logic        OUT_WRITE,
  input  wire logic [31:0] OUT_ADDR,
  input  wire logic [31:0] OUT_WDATA,
  output logic [31:0]      TGT_RDATA
);
  logic [31:0] mem [16];
  logic [31:0] rd_ff = 32'h0;
  logic        hold_ff = 1'h0;
  wire  logic  rd_beat = OUT_VALID === 1'h1 && OUT_RMW && !OUT_WRITE;
  initial
    for (int i = 0; i < 16; i++) mem[i] = 32'h5A3C_9600 | i;
  // data shown during the read beat and one cycle after, inverted otherwise
  assign TGT_RDATA = rd_beat ? mem[OUT_ADDR[5:2]] : hold_ff ? rd_ff : ~rd_ff;
  always @(posedge CLK)
  begin
    hold_ff <= rd_beat;
    if (rd_beat)
      rd_ff <= mem[OUT_ADDR[5:2]];
    if (OUT_VALID && OUT_RMW && OUT_WRITE)
      mem[OUT_ADDR[5:2]] <= OUT_WDATA;
  end
endmodule // tgt_model

// ---- tb/tb.sv ----
// self-checking bench for the memory map decoder
`timescale 1ns/1ns
module tb;
  import memmap_pkg::*;
  logic        clk, rst_b, ce, req_valid, req_write, from_core, sec_present;
  logic [31:0] req_addr, req_wdata, tgt_rdata, out_addr, out_wdata, resp_rdata;
  logic        out_valid, out_write, out_wake_sel, out_rmw, resp_valid;
  logic [1:0]  out_channel, resp_code;
  target_e     out_target;
  ecc_mode_e   out_ecc;
  int          n_fail = 0;
  int          checks = 0;
  memory_map_decoder i_dut (.CLK(clk), .RST_B(rst_b), .CE(ce), .REQ_VALID(req_valid),
    .REQ_ADDR(req_addr), .REQ_WRITE(req_write), .REQ_WDATA(req_wdata),
    .REQ_FROM_CORE(from_core), .REQ_DEDICATED(1'h0), .SEC_PRESENT(sec_present),
    .TGT_RDATA(tgt_rdata), .OUT_VALID(out_valid), .OUT_TARGET(out_target),
    .OUT_ADDR(out_addr), .OUT_WRITE(out_write), .OUT_WDATA(out_wdata), .OUT_ECC(out_ecc),
    .OUT_CHANNEL(out_channel), .OUT_WAKE_SEL(out_wake_sel), .OUT_RMW(out_rmw),
    .RESP_VALID(resp_valid), .RESP_CODE(resp_code), .RESP_RDATA(resp_rdata));
  tgt_model i_tgt (.CLK(clk), .OUT_VALID(out_valid), .OUT_RMW(out_rmw),
    .OUT_WRITE(out_write), .OUT_ADDR(out_addr), .OUT_WDATA(out_wdata), .TGT_RDATA(tgt_rdata));
  always #4 clk = ~clk;
  task automatic close_out;
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic req(input logic [31:0] a, input logic w, input logic [31:0] d);
    @(posedge clk);
    #1;
    req_addr = a;
    req_write = w;
    req_wdata = d;
    req_valid = 1'h1; // one word a request, never merged
    @(posedge clk);
    #1;
    req_valid = 1'h0;
  endtask
  task automatic fwd(input logic [31:0] a, input logic w, input logic [3:0] t,
                     input logic [31:0] o);
    req(a, w, 32'h0);
    chk({out_valid, resp_valid, resp_code, out_target, out_write}, {2'h3, RESP_OKAY, t, w});
    chk(out_addr, o);
  endtask
  task automatic err(input logic [31:0] a, input logic w, input logic [1:0] c);
    req(a, w, 32'h0);
    chk({out_valid, resp_valid, resp_code}, {2'h1, c});
  endtask
  // alias beats: read at +1, write-back at +2 for writes, answer last
  task automatic rmw(input logic [31:0] a, input logic w, input logic [31:0] d,
                     input logic [31:0] ta, input logic [31:0] e);
    req(a, w, d);
    chk({out_valid, out_rmw, out_write}, 3'h6);
    chk(out_addr, ta);
    if (w)
    begin
      @(posedge clk);
      #1;
      chk({out_valid, out_rmw, out_write, out_addr}, {3'h7, ta});
      chk(out_wdata, e);
    end
    @(posedge clk);
    #1;
    chk({resp_valid, resp_code}, {1'h1, RESP_OKAY});
    if (!w)
      chk(resp_rdata, e);
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_flash;
    fwd(32'h01AF_FFFC, 1'h0, TGT_PFLASH, 32'h000F_FFFC);
    fwd(32'h00AF_FFFC, 1'h0, TGT_PFLASH, 32'h000F_FFFC);
    chk(out_ecc, ECC_CORE);
    fwd(32'h019F_0020, 1'h0, TGT_SSFLASH, 32'h20);
    fwd(32'h009F_0020, 1'h0, TGT_SSFLASH, 32'h20);
    fwd(32'h01A0_0040, 1'h1, TGT_PFLASH, 32'h40);
    err(32'h00A0_0040, 1'h1, RESP_SLVERR);
    err(32'h009F_0040, 1'h1, RESP_SLVERR);
  endtask
  task automatic t_work;
    fwd(WF1_BASE + 32'h80, 1'h1, TGT_WFLASH, 32'h80);
    chk(out_ecc, ECC_GEN);
    fwd(WF3_BASE + 32'h80, 1'h1, TGT_WFLASH, 32'h80);
    chk(out_ecc, ECC_RAW);
    fwd(WF4_BASE + 32'hFFFC, 1'h0, TGT_WFLASH, 32'hFFFC);
    chk(out_ecc, ECC_CHK);
    err(WF1_BASE, 1'h0, RESP_SLVERR);
    err(WF4_BASE, 1'h1, RESP_SLVERR);
  endtask
  task automatic t_periph;
    for (int ch = 0; ch < SER_CH; ch++)
    begin
      fwd(SER_BASE + ch * SER_WIN + 32'h3FC, 1'h0, TGT_SERIAL, 32'h3FC);
      chk(out_channel, ch);
    end
    fwd(CNV1_BASE + 32'h10, 1'h0, TGT_CNV1, 32'h10);
    chk(out_wake_sel, 32'h1);
    fwd(CNV0_BASE + 32'h3FC, 1'h0, TGT_CNV0, 32'h3FC);
    chk(out_wake_sel, 32'h0);
  endtask
  task automatic t_access;
    err(32'h0000_1000, 1'h0, RESP_SLVERR);
    from_core = 1'h1;
    fwd(32'h0000_1000, 1'h0, TGT_CORE, 32'h0000_1000);
    from_core = 1'h0;
    err(32'hC000_0000, 1'h0, RESP_DECERR);
    err(32'hB120_0000, 1'h1, RESP_DECERR);
    err(SEC_BASE, 1'h0, RESP_SLVERR);
    sec_present = 1'h1;
    fwd(SEC_LAST - 32'h3, 1'h0, TGT_PERI, SEC_LAST - 32'h3);
  endtask
  task automatic t_alias;
    rmw(MCU_ALIAS_BASE + 32'h24, 1'h0, 32'h0, MCU_BASE, 32'h1);
    rmw(MCU_ALIAS_BASE + 32'h04, 1'h1, 32'h1, MCU_BASE, 32'h5A3C_9602);
    rmw(SYS_ALIAS_BASE + 32'h80, 1'h0, 32'h0, SYS_BASE + 32'h4, 32'h1);
    rmw(MEM_ALIAS_BASE + 32'h24, 1'h1, 32'h0, MEM_BASE, 32'h5A3C_9402);
  endtask
  // a low clock enable must stall an alias read, not lose it
  task automatic t_hold;
    req(MCU_ALIAS_BASE + 32'h04, 1'h0, 32'h0);
    ce = 1'h0;
    @(posedge clk);
    #1;
    chk({out_valid, out_rmw, out_write, resp_valid}, 4'hC);
    ce = 1'h1;
    @(posedge clk);
    #1;
    chk({resp_valid, resp_code}, {1'h1, RESP_OKAY});
    chk(resp_rdata, 32'h1);
  endtask
  initial
  begin
    clk = 1'h0;
    rst_b = 1'h0;
    ce = 1'h1;
    req_valid = 1'h0;
    req_write = 1'h0;
    from_core = 1'h0;
    sec_present = 1'h0;
    req_addr = 32'h0;
    req_wdata = 32'h0;
    repeat (4) @(posedge clk);
    #1;
    rst_b = 1'h1;
    t_flash;
    t_work;
    t_periph;
    t_access;
    t_alias;
    t_hold;
    close_out;
  end
  // whole run is near 70 cycles, so 2000 means a hang
  initial
  begin
    #(8 * 2000);
    n_fail++;
    close_out;
  end
endmodule // tb

bind memory_map_decoder mmd_props u_props (.CLK(CLK), .RST_B(RST_B), .CE(CE),
  .REQ_VALID(REQ_VALID), .REQ_ADDR(REQ_ADDR), .REQ_WRITE(REQ_WRITE),
  .REQ_FROM_CORE(REQ_FROM_CORE), .OUT_VALID(OUT_VALID), .OUT_TARGET(OUT_TARGET),
  .OUT_ADDR(OUT_ADDR), .OUT_WRITE(OUT_WRITE), .OUT_ECC(OUT_ECC), .OUT_CHANNEL(OUT_CHANNEL),
  .OUT_WAKE_SEL(OUT_WAKE_SEL), .OUT_RMW(OUT_RMW), .RESP_VALID(RESP_VALID),
  .RESP_CODE(RESP_CODE));
